// ==== rtl/smm_top.sv ====
// Supply min/max readout with a classic Wishbone register slave.
// Assumes conversion results arrive from logic on clk with a one-cycle valid strobe.
`timescale 1ns/10ps
module smm_top #(
  parameter int CODE_W = smm_pkg::CODE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [smm_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [smm_pkg::DAT_W-1:0] wb_dat_i,
  output logic [smm_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sample_valid,
  input wire logic [CODE_W-1:0] primary_supply_pin_code,
  input wire logic [CODE_W-1:0] secondary_supply_pin_code
);
  localparam int BW = smm_pkg::BYTE_W;
  localparam int NW = smm_pkg::NIB_W;

  smm_pkg::smm_bus_e bus_r;
  smm_pkg::smm_bus_e bus_nxt;
  logic req;
  logic taken;
  logic rd_taken;
  logic wr_ctrl;
  logic secondary_supply_present_r;
  logic clr_r;
  logic [CODE_W-1:0] cur_code;
  logic [BW-1:0] low_shadow;
  logic [BW-1:0] high_shadow;
  logic [smm_pkg::DAT_W-1:0] rd_data;
  logic [smm_pkg::DAT_W-1:0] dat_r;

  smm_trk_if #(.W(CODE_W)) low_if ();
  smm_trk_if #(.W(CODE_W)) high_if ();

  function automatic logic hit(input logic [smm_pkg::ADR_W-1:0] adr,
                               input logic [smm_pkg::IDX_W-1:0] idx);
    hit = (adr[smm_pkg::ADR_W-1:2] == idx) && (adr[1:0] == smm_pkg::ADR_ALIGN);
  endfunction

  function automatic logic [smm_pkg::DAT_W-1:0] nibble_word(input logic [CODE_W-1:0] v);
    nibble_word = {{(smm_pkg::DAT_W - NW){1'b0}}, v[BW +: NW]};
  endfunction

  function automatic logic [smm_pkg::DAT_W-1:0] byte_word(input logic [BW-1:0] v);
    byte_word = {{(smm_pkg::DAT_W - BW){1'b0}}, v};
  endfunction

  assign req = wb_cyc_i && wb_stb_i;
  assign taken = req && (bus_r == smm_pkg::SMM_BUS_IDLE);
  assign rd_taken = taken && !wb_we_i;
  assign wr_ctrl = taken && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, smm_pkg::IDX_CTRL);

  // Bus handshake: ack follows one cycle after the request is taken.
  always_comb begin
    case (bus_r)
      smm_pkg::SMM_BUS_IDLE: begin
        bus_nxt = req ? smm_pkg::SMM_BUS_ACK : smm_pkg::SMM_BUS_IDLE;
      end
      smm_pkg::SMM_BUS_ACK: begin
        bus_nxt = smm_pkg::SMM_BUS_IDLE;
      end
      default: begin
        bus_nxt = smm_pkg::SMM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_r <= smm_pkg::SMM_BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  assign wb_ack_o = (bus_r == smm_pkg::SMM_BUS_ACK);

  // Control register: presence bit is stored, clear bit is a self-clearing strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secondary_supply_present_r <= 1'b0;
    end else if (wr_ctrl) begin
      secondary_supply_present_r <= wb_dat_i[smm_pkg::CTRL_SEC_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_r <= 1'b0;
    end else begin
      clr_r <= wr_ctrl && wb_dat_i[smm_pkg::CTRL_CLR_BIT];
    end
  end

  // Source select.
  assign cur_code = secondary_supply_present_r ? secondary_supply_pin_code
                                               : primary_supply_pin_code;

  // Holding a whole pair, not one half, keeps nibble and byte from the same sample.
  assign low_if.sample_valid = sample_valid;
  assign low_if.sample_code = cur_code;
  assign low_if.clear = clr_r;
  assign low_if.hold = req && (hit(wb_adr_i, smm_pkg::IDX_LOW_HI)
                              || hit(wb_adr_i, smm_pkg::IDX_LOW_LO));
  assign high_if.sample_valid = sample_valid;
  assign high_if.sample_code = cur_code;
  assign high_if.clear = clr_r;
  assign high_if.hold = req && (hit(wb_adr_i, smm_pkg::IDX_HIGH_HI)
                               || hit(wb_adr_i, smm_pkg::IDX_HIGH_LO));

  smm_tracker #(.W(CODE_W), .KIND(smm_pkg::SMM_TRK_MIN)) u_low (
    .clk(clk),
    .rst_n(rst_n),
    .t(low_if.trk)
  );

  smm_tracker #(.W(CODE_W), .KIND(smm_pkg::SMM_TRK_MAX)) u_high (
    .clk(clk),
    .rst_n(rst_n),
    .t(high_if.trk)
  );

  smm_shadow #(.W(BW)) u_low_shadow (
    .clk(clk),
    .rst_n(rst_n),
    .capture(rd_taken && hit(wb_adr_i, smm_pkg::IDX_LOW_HI)),
    .live(low_if.value[BW-1:0]),
    .shadow(low_shadow)
  );

  smm_shadow #(.W(BW)) u_high_shadow (
    .clk(clk),
    .rst_n(rst_n),
    .capture(rd_taken && hit(wb_adr_i, smm_pkg::IDX_HIGH_HI)),
    .live(high_if.value[BW-1:0]),
    .shadow(high_shadow)
  );

  // Read mux; lower bytes come from the shadows, unmapped addresses read zero.
  always_comb begin
    rd_data = '0;
    if (hit(wb_adr_i, smm_pkg::IDX_LOW_HI)) begin
      rd_data = nibble_word(low_if.value);
    end else if (hit(wb_adr_i, smm_pkg::IDX_LOW_LO)) begin
      rd_data = byte_word(low_shadow);
    end else if (hit(wb_adr_i, smm_pkg::IDX_HIGH_HI)) begin
      rd_data = nibble_word(high_if.value);
    end else if (hit(wb_adr_i, smm_pkg::IDX_HIGH_LO)) begin
      rd_data = byte_word(high_shadow);
    end else if (hit(wb_adr_i, smm_pkg::IDX_CTRL)) begin
      rd_data[smm_pkg::CTRL_SEC_BIT] = secondary_supply_present_r;
      rd_data[smm_pkg::CTRL_TRK_BIT] = low_if.tracking;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_r <= '0;
    end else if (rd_taken) begin
      dat_r <= rd_data;
    end
  end

  assign wb_dat_o = dat_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_min_track;
    (sample_valid && !low_if.hold && !clr_r && low_if.tracking && cur_code < low_if.value)
      |=> (low_if.value == $past(cur_code));
  endproperty
  a_min_track: assert property (p_min_track) else $error("minimum not updated");

  property p_max_track;
    (sample_valid && !high_if.hold && !clr_r && high_if.tracking
      && cur_code > high_if.value) |=> (high_if.value == $past(cur_code));
  endproperty
  a_max_track: assert property (p_max_track) else $error("maximum not updated");

  property p_source;
    (sample_valid && !low_if.hold && !clr_r && !low_if.tracking)
      |=> (low_if.value == ($past(secondary_supply_present_r)
           ? $past(secondary_supply_pin_code) : $past(primary_supply_pin_code)));
  endproperty
  a_source: assert property (p_source) else $error("wrong supply source");

  property p_hold;
    (req && (hit(wb_adr_i, smm_pkg::IDX_HIGH_HI) || hit(wb_adr_i, smm_pkg::IDX_HIGH_LO)))
      |=> $stable(high_if.value);
  endproperty
  a_hold: assert property (p_hold) else $error("maximum changed while addressed");

  property p_shadow;
    (rd_taken && hit(wb_adr_i, smm_pkg::IDX_LOW_HI))
      |=> (low_shadow == $past(low_if.value[BW-1:0])) && wb_ack_o;
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not loaded");

  property p_low_read;
    (rd_taken && hit(wb_adr_i, smm_pkg::IDX_HIGH_LO))
      |=> wb_ack_o && (wb_dat_o == byte_word($past(high_shadow)));
  endproperty
  a_low_read: assert property (p_low_read) else $error("lower byte not from shadow");

  property p_clear;
    clr_r |=> !low_if.tracking && !high_if.tracking;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not restart tracking");

  // Back-to-back reads are taken two cycles apart at the earliest: ack, then the next take as the bus returns to idle.
  c_pair_read: cover property ((rd_taken && hit(wb_adr_i, smm_pkg::IDX_LOW_HI))
    ##[3:20] (rd_taken && hit(wb_adr_i, smm_pkg::IDX_LOW_LO)));
  c_held_sample: cover property (sample_valid && high_if.hold);
  c_clear_restart: cover property (clr_r ##[1:20] low_if.tracking);
endmodule

// ==== rtl/smm_pkg.sv ====
// Constants, types and register map of the supply min/max readout.
// Assumes a 32-bit classic Wishbone bus with word-aligned byte addresses.
package smm_pkg;
  localparam int CODE_W = 12;
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int IDX_W = 6;
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_LOW_HI = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_LOW_LO = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_HIGH_HI = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_HIGH_LO = 6'h20;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h10;
  localparam int CTRL_SEC_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_TRK_BIT = 2;
  localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;
  localparam logic [1:0] ADR_ALIGN = 2'h0;
  typedef enum logic {SMM_TRK_MIN, SMM_TRK_MAX} smm_kind_e;
  typedef enum logic {SMM_BUS_IDLE, SMM_BUS_ACK} smm_bus_e;
endpackage

// ==== rtl/smm_trk_if.sv ====
// Signals between the register front end and one min or max tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface smm_trk_if #(parameter int W = 12);
  logic sample_valid;
  logic [W-1:0] sample_code;
  logic clear;
  logic hold;
  logic [W-1:0] value;
  logic tracking;
  modport trk (input sample_valid, input sample_code, input clear, input hold,
               output value, output tracking);
  modport ctl (output sample_valid, output sample_code, output clear, output hold,
               input value, input tracking);
endinterface

// ==== rtl/smm_tracker.sv ====
// One running extreme tracker, minimum or maximum by parameter.
// Assumes samples, clear and hold come from logic on the same clock.
`timescale 1ns/10ps
module smm_tracker #(
  parameter int W = 12,
  parameter smm_pkg::smm_kind_e KIND = smm_pkg::SMM_TRK_MIN
) (
  input wire logic clk,
  input wire logic rst_n,
  smm_trk_if.trk t
);
  logic [W-1:0] value_r;
  logic tracking_r;
  logic better;
  logic take;

  always_comb begin
    if (KIND == smm_pkg::SMM_TRK_MAX) begin
      better = t.sample_code > value_r;
    end else begin
      better = t.sample_code < value_r;
    end
  end

  // A held sample is dropped rather than queued, so a read can miss one extreme.
  assign take = t.sample_valid && !t.hold && !t.clear && (!tracking_r || better);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_r <= '0;
    end else if (take) begin
      value_r <= t.sample_code;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tracking_r <= 1'b0;
    end else if (t.clear) begin
      tracking_r <= 1'b0;
    end else if (take) begin
      tracking_r <= 1'b1;
    end
  end

  assign t.value = value_r;
  assign t.tracking = tracking_r;
endmodule

// ==== rtl/smm_shadow.sv ====
// Shadow copy of a lower byte, loaded on a capture strobe.
// Assumes capture is a one-cycle strobe on the same clock.
`timescale 1ns/10ps
module smm_shadow #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic capture,
  input wire logic [W-1:0] live,
  output logic [W-1:0] shadow
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow <= '0;
    end else if (capture) begin
      shadow <= live;
    end
  end
endmodule

// ==== tb/smm_tb.sv ====
// Self-checking bench for the supply min/max readout, driven over classic Wishbone.
// Assumes smm_top with its package; the bench drives samples and the bus itself.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
  localparam logic [7:0] A_LH = {smm_pkg::IDX_LOW_HI, 2'b00};
  localparam logic [7:0] A_HH = {smm_pkg::IDX_HIGH_HI, 2'b00};
  localparam logic [7:0] A_CT = {smm_pkg::IDX_CTRL, 2'b00};
  logic clk = 1'b0;
  logic rst_n;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sample_valid;
  logic [11:0] p_code;
  logic [11:0] s_code;
  int n_mismatch = 0;
  int n_checks = 0;

  smm_top dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_valid(sample_valid),
    .primary_supply_pin_code(p_code), .secondary_supply_pin_code(s_code));

  always #25 clk = ~clk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One bus cycle; smp raises a sample in the very cycle the request is taken.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    input logic smp, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'h1;
    sample_valid <= smp;
    @(posedge clk);
    sample_valid <= 1'b0;
    while (wb_ack_o !== 1'b1) begin
      if (n == 20) begin
        n_mismatch++;
        $display("ERROR ack expected 1 seen timeout");
        test_done();
      end
      @(posedge clk);
      n++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic smp(input logic [11:0] p, input logic [11:0] s);
    @(posedge clk);
    sample_valid <= 1'b1;
    p_code <= p;
    s_code <= s;
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask

  task automatic chk_pair(input logic [7:0] hi, input logic [11:0] exp);
    logic [31:0] q;
    wb(1'b0, hi, 32'h0000_0000, 1'b0, q);
    `CHK("upper nibble", {28'h000_0000, exp[11:8]}, q)
    wb(1'b0, hi + 8'h04, 32'h0000_0000, 1'b0, q);
    `CHK("lower byte", {24'h00_0000, exp[7:0]}, q)
  endtask

  // Software view of a pair: join nibble and byte, then scale by num/100 millivolts per count.
  task automatic chk_mv(input logic [7:0] hi, input logic [31:0] num, input logic [31:0] mv);
    logic [31:0] qh;
    logic [31:0] ql;
    logic [31:0] got;
    wb(1'b0, hi, 32'h0000_0000, 1'b0, qh);
    wb(1'b0, hi + 8'h04, 32'h0000_0000, 1'b0, ql);
    got = ((qh[3:0] << 8) + ql[7:0]) * num / 32'h0000_0064;
    `CHK("millivolts", mv, got)
  endtask

  task automatic t_reset();
    logic [31:0] q;
    wb(1'b0, A_LH + 8'h04, 32'h0000_0000, 1'b0, q);
    `CHK("low mark lower reset", 32'h0000_0000, q)
    chk_pair(A_LH, 12'h000);
    chk_pair(A_HH, 12'h000);
    wb(1'b0, 8'h3c, 32'h0000_0000, 1'b0, q);
    `CHK("unmapped read", 32'h0000_0000, q)
  endtask

  task automatic t_track();
    logic [31:0] q;
    smp(12'h5a3, 12'h111);
    smp(12'h9c1, 12'hfff);
    smp(12'h2f7, 12'h001);
    chk_pair(A_LH, 12'h2f7);
    chk_mv(A_LH, 32'h0000_0095, 32'h0000_046a);
    chk_pair(A_HH, 12'h9c1);
    wb(1'b0, A_CT, 32'h0000_0000, 1'b0, q);
    `CHK("control after samples", 32'h0000_0004, q)
  endtask

  // A new minimum lands between the upper and lower reads: the lower read keeps the old byte.
  task automatic t_shadow();
    logic [31:0] q;
    wb(1'b0, A_LH, 32'h0000_0000, 1'b0, q);
    smp(12'h205, 12'h111);
    wb(1'b0, A_LH + 8'h04, 32'h0000_0000, 1'b0, q);
    `CHK("lower from shadow", 32'h0000_00f7, q)
    chk_pair(A_LH, 12'h205);
  endtask

  task automatic t_hold();
    logic [31:0] q;
    // The held sample is above the maximum, so only the hold keeps it out.
    p_code <= 12'hf00;
    wb(1'b0, A_HH, 32'h0000_0000, 1'b1, q);
    `CHK("upper during held sample", 32'h0000_0009, q)
    p_code <= 12'h100;
    wb(1'b0, A_LH + 8'h04, 32'h0000_0000, 1'b1, q);
    wb(1'b1, A_LH + 8'h04, 32'h0000_00ff, 1'b0, q);
    wb(1'b1, A_HH, 32'h0000_0000, 1'b0, q);
    chk_pair(A_HH, 12'h9c1);
    chk_pair(A_LH, 12'h205);
  endtask

  task automatic t_clear_sec();
    logic [31:0] q;
    wb(1'b1, A_CT, 32'h0000_0003, 1'b0, q);
    wb(1'b0, A_CT, 32'h0000_0000, 1'b0, q);
    `CHK("control after clear", 32'h0000_0001, q)
    chk_pair(A_LH, 12'h205);
    smp(12'h000, 12'h456);
    chk_pair(A_LH, 12'h456);
    chk_pair(A_HH, 12'h456);
    smp(12'heee, 12'h300);
    smp(12'h001, 12'h7a8);
    chk_pair(A_LH, 12'h300);
    chk_pair(A_HH, 12'h7a8);
    chk_mv(A_HH, 32'h0000_0065, 32'h0000_07bb);
  endtask

  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    sample_valid = 1'b0;
    p_code = 12'h000;
    s_code = 12'h000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_track();
    t_shadow();
    t_hold();
    t_clear_sec();
    test_done();
  end
endmodule
